// File: hw/audio_link_codec.sv
// codec end: makes the bit clock, decodes outbound frames, returns reads
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module audio_link_codec (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // link
  audio_link_if.codec_end link,
  // strap
  input wire logic [1:0] codec_number_setting,
  // register access toward the register file
  output logic reg_write_q,
  output logic reg_read_q,
  output logic [6:0] reg_index_q,
  output logic [15:0] write_value_q,
  input wire logic [15:0] read_value,
  // playback samples
  output logic sample_valid_q,
  output logic [3:0] sample_slot_q,
  output logic [19:0] playback_sample_q,
  // status
  output logic codec_ready_q
);

  // ====================================================================
  // input synchronisers
  logic reset_meta_q;
  logic reset_sync_q;
  logic sync_meta_q;
  logic sync_s_q;
  logic sdo_meta_q;
  logic sdo_s_q;
  logic run;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reset_meta_q <= 1'b0;
      reset_sync_q <= 1'b0;
      sync_meta_q <= 1'b0;
      sync_s_q <= 1'b0;
      sdo_meta_q <= 1'b0;
      sdo_s_q <= 1'b0;
    end else begin
      reset_meta_q <= link.reset_b;
      reset_sync_q <= reset_meta_q;
      sync_meta_q <= link.sync;
      sync_s_q <= sync_meta_q;
      sdo_meta_q <= link.sdata_out;
      sdo_s_q <= sdo_meta_q;
    end
  end

  // link reset from the controller holds the codec side past the input synchronisers
  assign run = rst_b & reset_sync_q;

  // strap is caught while the link is held in reset
  logic [1:0] own_id_q;

  always_ff @(posedge clock) begin
    if (!run) begin
      own_id_q <= codec_number_setting;
    end
  end

  // ====================================================================
  // bit clock divider
  logic [3:0] div_q;
  logic bit_clk_q;
  logic tick;
  logic rise_ev;
  logic fall_ev;

  assign tick = (div_q == audio_link_pkg::HALF_LAST);
  assign rise_ev = tick & ~bit_clk_q;
  assign fall_ev = tick & bit_clk_q;

  // clock stands still during link reset, restarts on release
  always_ff @(posedge clock) begin
    if (!run) begin
      div_q <= 4'h0;
      bit_clk_q <= 1'b0;
    end else if (tick) begin
      div_q <= 4'h0;
      bit_clk_q <= ~bit_clk_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign link.bit_clk = bit_clk_q;

  // ====================================================================
  // framing and lock
  logic sync_prev_q;
  logic frame_start;
  logic capture;
  logic [7:0] pos_q;
  logic seen_q;
  logic [1:0] lock_q;
  logic on_time;

  // rising sync seen at a falling bit clock edge
  assign frame_start = fall_ev & sync_s_q & ~sync_prev_q;
  assign capture = fall_ev & ~frame_start;
  assign on_time = seen_q & (pos_q == audio_link_pkg::LAST_POS);

  always_ff @(posedge clock) begin
    if (!run) begin
      sync_prev_q <= 1'b0;
      pos_q <= 8'h00;
      seen_q <= 1'b0;
      lock_q <= 2'h0;
    end else if (fall_ev) begin
      sync_prev_q <= sync_s_q;
      if (frame_start) begin
        pos_q <= 8'h00;
        seen_q <= 1'b1;
        if (!on_time) begin
          lock_q <= 2'h0;
        end else if (lock_q != audio_link_pkg::LOCK_FRAMES) begin
          lock_q <= lock_q + 2'h1;
        end
      end else begin
        pos_q <= pos_q + 8'h01;
        // no sync where the frame should have ended
        if (on_time) begin
          lock_q <= 2'h0;
        end
      end
    end
  end

  // cold reset clears ready; two good frames set it again
  always_ff @(posedge clock) begin
    if (!run) begin
      codec_ready_q <= 1'b0;
    end else begin
      codec_ready_q <= (lock_q == audio_link_pkg::LOCK_FRAMES);
    end
  end

  // ====================================================================
  // slot tracking and shift register
  logic [3:0] slot_q;
  logic [4:0] sbit_q;
  logic [19:0] word_q;
  logic [19:0] word_full;
  logic slot_end;

  assign word_full = {word_q[18:0], sdo_s_q};
  assign slot_end = capture & (slot_q <= audio_link_pkg::LAST_SLOT) &
    (sbit_q == ((slot_q == 4'h0) ? audio_link_pkg::TAG_LAST_BIT :
    audio_link_pkg::SLOT_LAST_BIT));

  always_ff @(posedge clock) begin
    if (!run || frame_start) begin
      slot_q <= 4'h0;
      sbit_q <= 5'h00;
      word_q <= 20'h00000;
    end else if (capture) begin
      word_q <= word_full;
      if (slot_end) begin
        slot_q <= slot_q + 4'h1;
        sbit_q <= 5'h00;
      end else begin
        sbit_q <= sbit_q + 5'h01;
      end
    end
  end

  // ====================================================================
  // command decode
  logic [15:0] tag_q;
  logic [19:0] cmd_q;
  logic is_read;
  logic slot_ok;
  logic access_ok;

  assign is_read = cmd_q[audio_link_pkg::CMD_READ_BIT];
  // primary wants slot 1 (and 2 for writes), secondary wants neither
  assign slot_ok = (own_id_q == audio_link_pkg::PRIMARY_ID) ?
    (tag_q[audio_link_pkg::TAG_SLOT1_VALID] &
    (is_read | tag_q[audio_link_pkg::TAG_SLOT2_VALID])) :
    ~(tag_q[audio_link_pkg::TAG_SLOT1_VALID] | tag_q[audio_link_pkg::TAG_SLOT2_VALID]);
  assign access_ok = codec_ready_q & tag_q[audio_link_pkg::TAG_FRAME_VALID] &
    (tag_q[1:0] == own_id_q) & slot_ok & ~cmd_q[audio_link_pkg::INDEX_LO];

  always_ff @(posedge clock) begin
    if (!run) begin
      tag_q <= 16'h0000;
      cmd_q <= 20'h00000;
    end else if (slot_end && slot_q == 4'h0) begin
      tag_q <= word_full[15:0];
    end else if (slot_end && slot_q == audio_link_pkg::CMD_SLOT) begin
      cmd_q <= word_full;
    end
  end

  // one-cycle strobes toward the register file
  always_ff @(posedge clock) begin
    if (!run) begin
      reg_write_q <= 1'b0;
      reg_read_q <= 1'b0;
      reg_index_q <= 7'h00;
      write_value_q <= 16'h0000;
    end else begin
      reg_write_q <= 1'b0;
      reg_read_q <= 1'b0;
      if (slot_end && slot_q == audio_link_pkg::DATA_SLOT && access_ok) begin
        reg_index_q <= cmd_q[audio_link_pkg::INDEX_HI:audio_link_pkg::INDEX_LO];
        if (is_read) begin
          reg_read_q <= 1'b1;
        end else begin
          reg_write_q <= 1'b1;
          write_value_q <= word_full[audio_link_pkg::VALUE_HI:audio_link_pkg::VALUE_LO];
        end
      end
    end
  end

  // ====================================================================
  // playback slots; slot to converter mapping is left to the consumer
  always_ff @(posedge clock) begin
    if (!run) begin
      sample_valid_q <= 1'b0;
      sample_slot_q <= 4'h0;
      playback_sample_q <= 20'h00000;
    end else begin
      sample_valid_q <= 1'b0;
      if (slot_end && slot_q >= audio_link_pkg::FIRST_PLAY_SLOT &&
          slot_q <= audio_link_pkg::LAST_PLAY_SLOT && codec_ready_q &&
          tag_q[audio_link_pkg::TAG_FRAME_VALID] &&
          tag_q[audio_link_pkg::tag_pos(slot_q)]) begin
        sample_valid_q <= 1'b1;
        sample_slot_q <= slot_q;
        playback_sample_q <= word_full;
      end
    end
  end

  // ====================================================================
  // inbound frame: ready tag, echoed index and read data
  logic ret_valid_q;
  logic [6:0] ret_index_q;
  logic [15:0] ret_data_q;
  logic [audio_link_pkg::RETURN_BITS-1:0] out_q;
  logic sdata_in_q;

  // read data is sampled in the cycle the read strobe stands
  always_ff @(posedge clock) begin
    if (!run) begin
      ret_valid_q <= 1'b0;
      ret_index_q <= 7'h00;
      ret_data_q <= 16'h0000;
    end else if (reg_read_q) begin
      ret_valid_q <= 1'b1;
      ret_index_q <= reg_index_q;
      ret_data_q <= read_value;
    end else if (frame_start) begin
      ret_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!run) begin
      out_q <= '0;
      sdata_in_q <= 1'b0;
    end else if (frame_start) begin
      out_q <= {codec_ready_q, ret_valid_q, ret_valid_q, 13'h0000,
        1'b0, ret_valid_q ? ret_index_q : 7'h00, 12'h000,
        ret_valid_q ? ret_data_q : 16'h0000, 4'h0};
    end else if (rise_ev) begin
      sdata_in_q <= out_q[audio_link_pkg::RETURN_BITS-1];
      out_q <= {out_q[audio_link_pkg::RETURN_BITS-2:0], 1'b0};
    end
  end

  assign link.sdata_in = sdata_in_q;

endmodule : audio_link_codec

// File: hw/audio_link_controller.sv
// controller end: ahb-lite register slave that runs outbound frames
`timescale 1ns/100ps
module audio_link_controller (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // link
  audio_link_if.controller_end link
);

  // ====================================================================
  // bus slave: one wait state on every transfer, always okay
  logic pend_q;
  logic a_write_q;
  logic [7:0] a_addr_q;
  logic [31:0] rd_word;
  logic wr_now;

  assign wr_now = pend_q & a_write_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      a_write_q <= 1'b0;
      a_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      hreadyout <= 1'b1;
      if (!a_write_q) begin
        hrdata <= rd_word;
      end
    end else if (hsel && htrans[1] && hready) begin
      pend_q <= 1'b1;
      hreadyout <= 1'b0;
      a_write_q <= hwrite;
      a_addr_q <= haddr[7:0];
    end
  end

  // ====================================================================
  // registers
  logic [1:0] ctrl_q;
  logic busy_q;
  logic sent_q;
  logic cmd_read_q;
  logic [1:0] cmd_id_q;
  logic [6:0] cmd_index_q;
  logic [15:0] cmd_value_q;
  logic [19:0] play_q;
  logic ready_q;
  logic rvalid_q;
  logic [6:0] r_index_q;
  logic [15:0] r_data_q;
  logic [1:0] wait_q;
  logic load;
  logic last_fetch;

  always_comb begin
    rd_word = 32'h00000000;
    case (a_addr_q)
      audio_link_pkg::CTRL_ADDR: rd_word[1:0] = ctrl_q;
      audio_link_pkg::CMD_ADDR: rd_word = {cmd_read_q, 5'h00, cmd_id_q, 1'b0, cmd_index_q,
        cmd_value_q};
      audio_link_pkg::STATUS_ADDR: rd_word[2:0] = {rvalid_q, busy_q, ready_q};
      audio_link_pkg::RDATA_ADDR: rd_word = {9'h000, r_index_q, r_data_q};
      audio_link_pkg::PLAY_ADDR: rd_word[19:0] = play_q;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= 2'h0;
      play_q <= 20'h00000;
    end else if (wr_now && a_addr_q == audio_link_pkg::CTRL_ADDR) begin
      ctrl_q <= hwdata[1:0];
    end else if (wr_now && a_addr_q == audio_link_pkg::PLAY_ADDR) begin
      play_q <= hwdata[19:0];
    end
  end

  // a command written while busy is dropped
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      sent_q <= 1'b0;
      cmd_read_q <= 1'b0;
      cmd_id_q <= 2'h0;
      cmd_index_q <= 7'h00;
      cmd_value_q <= 16'h0000;
      wait_q <= 2'h0;
    end else if (wr_now && a_addr_q == audio_link_pkg::CMD_ADDR && !busy_q) begin
      busy_q <= 1'b1;
      sent_q <= 1'b0;
      cmd_read_q <= hwdata[audio_link_pkg::CMD_READ];
      cmd_id_q <= hwdata[audio_link_pkg::CMD_ID_LO+:2];
      cmd_index_q <= hwdata[audio_link_pkg::CMD_INDEX_LO+:7];
      cmd_value_q <= hwdata[15:0];
    end else if (load && busy_q && !sent_q) begin
      sent_q <= 1'b1;
      busy_q <= cmd_read_q;
      wait_q <= {1'b0, cmd_read_q};
    end else if (load && wait_q == 2'h1) begin
      wait_q <= 2'h2;
    end else if (last_fetch && wait_q == 2'h2) begin
      busy_q <= 1'b0;
      wait_q <= 2'h0;
    end
  end

  // ====================================================================
  // link pins sampled through two flip-flops
  logic bc_meta_q;
  logic bc_s_q;
  logic bc_prev_q;
  logic sdi_meta_q;
  logic sdi_s_q;
  logic rise;
  logic fall;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bc_meta_q <= 1'b0;
      bc_s_q <= 1'b0;
      bc_prev_q <= 1'b0;
      sdi_meta_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end else begin
      bc_meta_q <= link.bit_clk;
      bc_s_q <= bc_meta_q;
      bc_prev_q <= bc_s_q;
      sdi_meta_q <= link.sdata_in;
      sdi_s_q <= sdi_meta_q;
    end
  end

  assign rise = bc_s_q & ~bc_prev_q;
  assign fall = ~bc_s_q & bc_prev_q;

  // ====================================================================
  // outbound frame
  logic reset_b_q;
  logic sync_q;
  logic sdo_q;
  logic [7:0] pos_q;
  logic [7:0] drv_pos_q;
  logic [audio_link_pkg::SEND_BITS-1:0] frame_q;
  logic send_cmd;
  logic play_en;
  logic primary;
  logic [15:0] tag;

  assign load = reset_b_q & rise & (pos_q == audio_link_pkg::LAST_POS);
  assign send_cmd = busy_q & ~sent_q;
  assign play_en = ctrl_q[audio_link_pkg::CTRL_PLAY];
  assign primary = (cmd_id_q == audio_link_pkg::PRIMARY_ID);
  // slots 3 and 4 carry the playback sample; reserved bits stay zero
  assign tag = {send_cmd | play_en, send_cmd & primary, send_cmd & primary & ~cmd_read_q,
    play_en, play_en, 9'h000, send_cmd ? cmd_id_q : 2'h0};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reset_b_q <= 1'b0;
    end else begin
      reset_b_q <= ctrl_q[audio_link_pkg::CTRL_RELEASE];
    end
  end

  assign link.reset_b = reset_b_q;

  // sync rises with f255 and stays up for sixteen bit times
  always_ff @(posedge clock) begin
    if (!reset_b_q) begin
      pos_q <= audio_link_pkg::LAST_POS;
      drv_pos_q <= audio_link_pkg::LAST_POS;
      sync_q <= 1'b0;
      sdo_q <= 1'b0;
      frame_q <= '0;
    end else if (rise) begin
      sdo_q <= frame_q[audio_link_pkg::SEND_BITS-1];
      drv_pos_q <= pos_q;
      pos_q <= pos_q + 8'h01;
      sync_q <= (pos_q == audio_link_pkg::LAST_POS) ||
        (pos_q < audio_link_pkg::SYNC_HIGH_BITS);
      if (load) begin
        frame_q <= {tag, cmd_read_q & send_cmd,
          send_cmd ? cmd_index_q : 7'h00, 12'h000,
          (send_cmd & ~cmd_read_q) ? cmd_value_q : 16'h0000, 4'h0,
          play_en ? play_q : 20'h00000, play_en ? play_q : 20'h00000};
      end else begin
        frame_q <= {frame_q[audio_link_pkg::SEND_BITS-2:0], 1'b0};
      end
    end
  end

  assign link.sync = sync_q;
  assign link.sdata_out = sdo_q;

  // ====================================================================
  // inbound capture of tag, echoed index and read data
  logic [audio_link_pkg::RETURN_BITS-1:0] in_q;
  logic [audio_link_pkg::RETURN_BITS-1:0] in_full;

  assign in_full = {in_q[audio_link_pkg::RETURN_BITS-2:0], sdi_s_q};
  assign last_fetch = reset_b_q & fall & (drv_pos_q == audio_link_pkg::RETURN_LAST_POS);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      in_q <= '0;
      ready_q <= 1'b0;
      rvalid_q <= 1'b0;
      r_index_q <= 7'h00;
      r_data_q <= 16'h0000;
    end else if (!reset_b_q) begin
      ready_q <= 1'b0;
    end else if (fall) begin
      in_q <= in_full;
      if (last_fetch) begin
        ready_q <= in_full[audio_link_pkg::RETURN_BITS-1];
        if (wait_q == 2'h2) begin
          // tag sits above slots 1 and 2 in the capture window
          rvalid_q <= in_full[2 * audio_link_pkg::SLOT_BITS + audio_link_pkg::TAG_SLOT1_VALID] &
            in_full[2 * audio_link_pkg::SLOT_BITS + audio_link_pkg::TAG_SLOT2_VALID];
          r_index_q <= in_full[audio_link_pkg::SLOT_BITS + audio_link_pkg::INDEX_HI:
            audio_link_pkg::SLOT_BITS + audio_link_pkg::INDEX_LO];
          r_data_q <= in_full[audio_link_pkg::VALUE_HI:audio_link_pkg::VALUE_LO];
        end
      end
    end
  end

endmodule : audio_link_controller

// File: hw/audio_link_if.sv
// the five wires of the serial audio link between controller and codec
`timescale 1ns/100ps
interface audio_link_if;
  logic bit_clk;
  logic sync;
  logic sdata_out;
  logic sdata_in;
  logic reset_b;

  modport codec_end (
    output bit_clk,
    output sdata_in,
    input sync,
    input sdata_out,
    input reset_b
  );

  modport controller_end (
    input bit_clk,
    input sdata_in,
    output sync,
    output sdata_out,
    output reset_b
  );
endinterface : audio_link_if

// File: hw/audio_link_pkg.sv
// shared constants and helpers for both ends of the serial audio link
// ====================================================================
// What this block does
// - frame is 256 bits in 13 slots
// - tag slot 16 bits, other slots 20
// - codec end generates the serial bit clock
// - sync sampled high on fall starts frame
// - first tag bit driven next rise, captured next fall
// - playback samples msb first, left justified
// - controller drives reserved bits as zero
// - tag bit 15 clear: ignore the frame
// - tag bits 14, 13 qualify slots 1, 2
// - tag bits 12..5 qualify playback slots 3..10
// - two lowest tag bits select the codec
// - access needs valid frame, match, slot validity
// - slot 1 bit 19: one read, zero write
// - slot 1 bits 18..12 index, low bit zero
// - slot 2 holds write value, ignored on read
// - write sends index and value in one frame
// - read data returns in next inbound frame
// - playback slots carry 20-bit samples, mapped downstream
// - ready only once link is synchronised
// - controller resets codec over active low line
// - inbound tag bit 15 is ready; gates accesses
// - inbound slot 1 echoes index for reads only
package audio_link_pkg;

  // ====================================================================
  // frame layout
  localparam int FRAME_BITS = 256;
  localparam int SLOT_COUNT = 13;
  localparam int TAG_BITS = 16;
  localparam int SLOT_BITS = 20;
  localparam logic [7:0] LAST_POS = 8'(FRAME_BITS - 1);
  localparam logic [3:0] LAST_SLOT = 4'(SLOT_COUNT - 1);
  localparam logic [4:0] TAG_LAST_BIT = 5'(TAG_BITS - 1);
  localparam logic [4:0] SLOT_LAST_BIT = 5'(SLOT_BITS - 1);
  localparam logic [7:0] SYNC_HIGH_BITS = 8'(TAG_BITS - 1);
  localparam logic [3:0] CMD_SLOT = 4'h1;
  localparam logic [3:0] DATA_SLOT = 4'h2;
  localparam logic [3:0] FIRST_PLAY_SLOT = 4'h3;
  localparam logic [3:0] LAST_PLAY_SLOT = 4'ha;

  // ====================================================================
  // field positions
  localparam int TAG_FRAME_VALID = 15;
  localparam int TAG_SLOT1_VALID = 14;
  localparam int TAG_SLOT2_VALID = 13;
  localparam int CMD_READ_BIT = 19;
  localparam int INDEX_HI = 18;
  localparam int INDEX_LO = 12;
  localparam int VALUE_HI = 19;
  localparam int VALUE_LO = 4;
  localparam logic [1:0] PRIMARY_ID = 2'h0;
  // inbound part that carries anything: tag, slot 1, slot 2
  localparam int RETURN_BITS = TAG_BITS + 2 * SLOT_BITS;
  localparam logic [7:0] RETURN_LAST_POS = 8'(RETURN_BITS - 1);
  // outbound part that carries anything: tag and slots 1 to 4
  localparam int SEND_BITS = TAG_BITS + 4 * SLOT_BITS;

  // ====================================================================
  // timing
  localparam int CLOCK_MHZ = 250;
  localparam int BIT_CLK_HALF_NS = 32;
  localparam int BIT_HALF_CYCLES = BIT_CLK_HALF_NS * CLOCK_MHZ / 1000;
  localparam logic [3:0] HALF_LAST = 4'(BIT_HALF_CYCLES - 1);
  localparam logic [1:0] LOCK_FRAMES = 2'h2;

  // ====================================================================
  // controller register map, byte addresses on the ahb-lite bus
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] CMD_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] RDATA_ADDR = 8'h0c;
  localparam logic [7:0] PLAY_ADDR = 8'h10;
  localparam int CTRL_RELEASE = 0;
  localparam int CTRL_PLAY = 1;
  localparam int CMD_READ = 31;
  localparam int CMD_ID_LO = 24;
  localparam int CMD_INDEX_LO = 16;
  localparam int STAT_READY = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_RVALID = 2;

  // tag bit that qualifies a slot
  function automatic logic [3:0] tag_pos(input logic [3:0] slot);
    tag_pos = 4'(TAG_FRAME_VALID) - slot;
  endfunction : tag_pos

endpackage : audio_link_pkg

// File: sim/audio_link_assertions.sv
// checker on the five link wires between controller and codec
`timescale 1ns/100ps
module audio_link_assertions (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // link
  input wire logic bit_clk,
  input wire logic sync,
  input wire logic sdata_out,
  input wire logic sdata_in,
  input wire logic reset_b
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // cycles since the last sync rise, saturating so idle is quiet
  logic sync_q;
  logic seen_q;
  logic [12:0] since_q;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync_q <= 1'b0;
      since_q <= 13'h1fff;
    end else begin
      sync_q <= sync;
      if (sync && !sync_q) begin
        since_q <= 13'h1;
      end else if (since_q != 13'h1fff) begin
        since_q <= since_q + 13'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
    end else if (sync && !sync_q) begin
      seen_q <= 1'b1;
    end
  end
  // ==========================================================
  // assertions
  property p_clk_stop; !reset_b [*8] |-> !bit_clk; endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("bit clock runs in link reset");
  property p_clk_high; $rose(bit_clk) && reset_b |-> bit_clk [*8] ##1 !bit_clk; endproperty
  a_clk_high: assert property (p_clk_high) else $error("bit clock high time wrong");
  property p_clk_low; $fell(bit_clk) && reset_b |-> !bit_clk [*8] ##1 bit_clk; endproperty
  a_clk_low: assert property (p_clk_low) else $error("bit clock low time wrong");
  property p_sync_width; sync_q && !sync |-> since_q == 13'h100; endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync not 16 bits high");
  property p_frame_len; sync && !sync_q && seen_q |-> since_q == 13'h1000; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 256 bits");
  property p_out_edge; $changed(sdata_out) || $changed(sync) |-> bit_clk; endproperty
  a_out_edge: assert property (p_out_edge) else $error("outbound change off rise");
  property p_in_edge; reset_b && $changed(sdata_in) |-> bit_clk; endproperty
  a_in_edge: assert property (p_in_edge) else $error("inbound change off rise");
  property p_in_quiet;
    seen_q && since_q >= 13'h3e8 && since_q <= 13'hfa0 |-> !sdata_in;
  endproperty
  a_in_quiet: assert property (p_in_quiet) else $error("inbound unused slot not zero");
endmodule : audio_link_assertions

// File: sim/tb.sv
// self-checking bench: ahb-lite master on the controller, codec on the link
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // signals
  logic clock, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic reg_write_q, reg_read_q, sample_valid_q, codec_ready_q;
  logic bad_slot = 1'b0;
  logic [6:0] reg_index_q;
  logic [15:0] write_value_q, read_value;
  logic [15:0] mem [128];
  logic [3:0] sample_slot_q;
  logic [19:0] playback_sample_q;
  logic [19:0] last_sample = 20'h00000;
  int err_count = 0, checked = 0, writes = 0, samples = 0, n;
  audio_link_if audio_link_if_inst ();
  audio_link_controller audio_link_controller_inst (.clock(clock), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(audio_link_if_inst));
  audio_link_codec audio_link_codec_inst (.clock(clock), .rst_b(rst_b),
    .link(audio_link_if_inst), .codec_number_setting(2'h0), .reg_write_q(reg_write_q),
    .reg_read_q(reg_read_q), .reg_index_q(reg_index_q), .write_value_q(write_value_q),
    .read_value(read_value), .sample_valid_q(sample_valid_q),
    .sample_slot_q(sample_slot_q), .playback_sample_q(playback_sample_q),
    .codec_ready_q(codec_ready_q));
  audio_link_assertions audio_link_assertions_inst (.clock(clock), .rst_b(rst_b),
    .bit_clk(audio_link_if_inst.bit_clk), .sync(audio_link_if_inst.sync),
    .sdata_out(audio_link_if_inst.sdata_out), .sdata_in(audio_link_if_inst.sdata_in),
    .reset_b(audio_link_if_inst.reset_b));
  // ==========================================================
  // register file model behind the codec, and sample monitor
  assign read_value = mem[reg_index_q];
  always @(posedge clock) begin
    if (reg_write_q === 1'b1) begin
      mem[reg_index_q] <= write_value_q;
      writes <= writes + 1;
    end
    if (sample_valid_q === 1'b1) begin
      samples <= samples + 1;
      last_sample <= playback_sample_q;
      bad_slot <= bad_slot | (sample_slot_q !== 4'h3 && sample_slot_q !== 4'h4);
    end
  end
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t mismatch got %h exp %h", $time, seen, exp);
    end
  endtask : check
  // called just after a rising edge; holds each phase until hready is seen high
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : rdc
  task poll(input int b, input logic v);
    n = 0;
    do begin
      ahb(1'b0, audio_link_pkg::STATUS_ADDR, 32'h0);
      n++;
    end while (rd[b] !== v && n < 6000);
    check({31'h0, rd[b]}, {31'h0, v});
  endtask : poll
  // a write strobe would land near bit 55 of the frame that clears busy
  task cmd(input logic r, input logic [1:0] s, input logic [6:0] i, input logic [15:0] v);
    ahb(1'b1, audio_link_pkg::CMD_ADDR, {r, 5'h0, s, 1'b0, i, v});
    poll(audio_link_pkg::STAT_BUSY, 1'b0);
    repeat (1200) @(posedge clock);
  endtask : cmd
  task end_of_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // tests
  initial begin
    {rst_b, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rdc(audio_link_pkg::STATUS_ADDR, 32'h0);
    rdc(8'h14, 32'h0);
    ahb(1'b1, audio_link_pkg::CTRL_ADDR, 32'h1);
    poll(audio_link_pkg::STAT_READY, 1'b1);
    check({31'h0, codec_ready_q}, 32'h1);
    $display("test ready done");
    cmd(1'b0, 2'h0, 7'h02, 16'h1234);
    check(writes, 1);
    check({16'h0, mem[2]}, 32'h1234);
    cmd(1'b1, 2'h0, 7'h02, 16'hffff);
    poll(audio_link_pkg::STAT_RVALID, 1'b1);
    rdc(audio_link_pkg::RDATA_ADDR, 32'h00021234);
    check(writes, 1);
    $display("test access done");
    for (int s = 1; s < 4; s++) begin
      cmd(1'b0, 2'(s), 7'h04, 16'h5555);
    end
    cmd(1'b0, 2'h0, 7'h03, 16'h5555);
    check(writes, 1);
    $display("test refuse done");
    ahb(1'b1, audio_link_pkg::PLAY_ADDR, 32'habcde);
    ahb(1'b1, audio_link_pkg::CTRL_ADDR, 32'h3);
    repeat (8192) @(posedge clock);
    check({31'h0, samples > 1}, 32'h1);
    check({12'h0, last_sample}, 32'habcde);
    check({31'h0, bad_slot}, 32'h0);
    ahb(1'b1, audio_link_pkg::CTRL_ADDR, 32'h1);
    repeat (4096) @(posedge clock);
    n = samples;
    repeat (8192) @(posedge clock);
    check(samples, n);
    $display("test playback done");
    end_of_test();
  end
  initial begin
    repeat (95000) @(posedge clock);
    err_count++;
    end_of_test();
  end
endmodule : tb
